// [src/fpu_exc_params.svh]
// constants for the numeric exception unit
`ifndef FPU_EXC_PARAMS_SVH
`define FPU_EXC_PARAMS_SVH

// =====================================================
// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STAT 8'h04
`define OFS_CMD 8'h08
`define OFS_MODE 8'h0c
`define OFS_W 8

// =====================================================
// field layout
`define NEXC 6
`define CTRL_MASK_LSB 0
`define CTRL_RND_LSB 10
`define STAT_SF_BIT 6
`define STAT_ES_BIT 7
`define STAT_FRZ_BIT 8
`define STAT_ERR_BIT 9
`define CMD_CLEAR_BIT 0
`define CMD_REINIT_BIT 1
`define CMD_SAVE_BIT 2
`define MODE_NATIVE_BIT 0

// =====================================================
// exception class bit positions
`define EXC_INV 0
`define EXC_DEN 1
`define EXC_ZDIV 2
`define EXC_OVF 3
`define EXC_UNF 4
`define EXC_PREC 5

// =====================================================
// reset values
`define MASK_RST 6'h3f
`define RND_RST 2'h0
`define NATIVE_RST 1'h0

`endif

// [src/fpu_exc_pkg.sv]
// types for the numeric exception unit
package fpu_exc_pkg;
	typedef logic [5:0] exc_vec_t;
	typedef enum logic [1:0]
	{
		round_nearest_t_v = 2'h0,
		round_down_t_v = 2'h1,
		round_up_t_v = 2'h2,
		round_chop_t_v = 2'h3
	} round_mode_t;
	typedef enum logic [1:0]
	{
		st_idle = 2'h0,
		st_pend = 2'h1,
		st_frozen = 2'h3
	} exc_state_t;
endpackage

// [src/exc_resolve.sv]
// splits detected exceptions into masked fix-ups and unmasked faults
`timescale 1ns/1ps
`include "fpu_exc_params.svh"
module exc_resolve
(
	input wire fpu_exc_pkg::exc_vec_t raw_exc,
	input wire fpu_exc_pkg::exc_vec_t mask,
	input wire tiny_below_denorm,
	output fpu_exc_pkg::exc_vec_t fixup,
	output logic unmasked_any,
	output logic store_zero,
	output logic store_denorm
);
	import fpu_exc_pkg::*;

	// =====================================================
	// classification
	always_comb
	begin
		fixup = raw_exc & mask;
		unmasked_any = |(raw_exc & ~mask);
		// masked underflow: denormal, or zero below smallest denormal
		store_denorm = fixup[`EXC_UNF] & ~tiny_below_denorm;
		store_zero = fixup[`EXC_UNF] & tiny_below_denorm;
	end
endmodule

// [src/fpu_exc_unit.sv]
// numeric exception flags, masks and legacy error reporting
// Behaviour
// - detect six classes: invalid (stack/arith), zero-divide, denormal, over, under, inexact
// - each class has one status flag and one control mask bit
// - masked exception gets default fix-up within the same instruction
// - masked exception sets flag only, no pin, no location kept
// - several masked exceptions may be flagged in one instruction
// - masked underflow stores denormal, or zero below smallest denormal
// - rounding control offers nearest, chop, up and down
// - flags sticky; cleared only by clear, reinit, save or restore
// - unmasked exception aborts the faulting instruction, handler is invoked
// - legacy mode, ignore inactive: handler via interrupt controller and pin
// - error pin rises at detection or at next wait/numeric instruction
// - pending unmasked fault freezes next wait/numeric, not no-wait ones
// - frozen until an enabled external interrupt arrives or the pending fault is cleared
// - legacy mode with ignore active: disregard fault, never freeze
// - coprocessor signals unmasked fault over dedicated error line in legacy mode; in native mode over the native trap output
// - clearing the pending fault drops the error pin
// - legacy reporting chosen while native reporting bit is zero
`timescale 1ns/1ps
`include "fpu_exc_params.svh"
module fpu_exc_unit
(
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire op_done,
	input wire fpu_exc_pkg::exc_vec_t op_exc,
	input wire op_stack_fault,
	input wire op_tiny_zero,
	input wire op_immediate,
	input wire op_sync,
	input wire op_nowait,
	input wire irq_enable,
	input wire ignore_numeric_error_in_n,
	input wire maskable_interrupt_in,
	output logic numeric_error_out,
	output logic freeze_out,
	output logic abort_out,
	output logic native_trap_out,
	output fpu_exc_pkg::exc_vec_t fixup_out,
	output logic uf_zero_out,
	output logic uf_denorm_out,
	output fpu_exc_pkg::round_mode_t round_mode_out
);
	import fpu_exc_pkg::*;

	// =====================================================
	// pin synchronisers
	logic ign_s1_r, ign_s2_r, irq_s1_r, irq_s2_r;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ign_s1_r <= 1'h1;
			ign_s2_r <= 1'h1;
			irq_s1_r <= 1'h0;
			irq_s2_r <= 1'h0;
		end
		else
		begin
			ign_s1_r <= ignore_numeric_error_in_n;
			ign_s2_r <= ign_s1_r;
			irq_s1_r <= maskable_interrupt_in;
			irq_s2_r <= irq_s1_r;
		end
	end

	// =====================================================
	// bus slave: zero wait states, read data staged in address phase
	logic wr_r;
	logic [`OFS_W-1:0] waddr_r;
	logic a_take;
	logic [31:0] rd_nxt;
	exc_vec_t mask_r, flags_r;
	logic sf_r, native_r, err_r;
	round_mode_t rnd_r;
	exc_state_t st_r, st_nxt;

	assign a_take = hsel & htrans[1] & hready;

	always_comb
	begin
		rd_nxt = 32'h0;
		unique case (haddr[`OFS_W-1:0])
		`OFS_CTRL:
		begin
			rd_nxt[`CTRL_MASK_LSB +: `NEXC] = mask_r;
			rd_nxt[`CTRL_RND_LSB +: 2] = rnd_r;
		end
		`OFS_STAT:
		begin
			rd_nxt[`NEXC-1:0] = flags_r;
			rd_nxt[`STAT_SF_BIT] = sf_r;
			rd_nxt[`STAT_ES_BIT] = (st_r != st_idle);
			rd_nxt[`STAT_FRZ_BIT] = (st_r == st_frozen);
			rd_nxt[`STAT_ERR_BIT] = err_r;
		end
		`OFS_MODE: rd_nxt[`MODE_NATIVE_BIT] = native_r;
		default: rd_nxt = 32'h0;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_r <= 1'h0;
			waddr_r <= 8'h0;
			hrdata <= 32'h0;
			hreadyout <= 1'h1;
			hresp <= 1'h0;
		end
		else
		begin
			wr_r <= a_take & hwrite;
			waddr_r <= haddr[`OFS_W-1:0];
			if (a_take & !hwrite)
				hrdata <= rd_nxt;
		end
	end

	// =====================================================
	// write decode in data phase
	logic w_ctrl, w_stat, w_cmd, w_mode, clr_op, init_op, clear_evt;
	assign w_ctrl = wr_r & (waddr_r == `OFS_CTRL);
	assign w_stat = wr_r & (waddr_r == `OFS_STAT);
	assign w_cmd = wr_r & (waddr_r == `OFS_CMD);
	assign w_mode = wr_r & (waddr_r == `OFS_MODE);
	assign clr_op = w_cmd & hwdata[`CMD_CLEAR_BIT];
	// save reinitialises as well
	assign init_op = w_cmd & (hwdata[`CMD_REINIT_BIT] |
		hwdata[`CMD_SAVE_BIT]);
	assign clear_evt = clr_op | init_op | w_stat;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mask_r <= `MASK_RST;
			rnd_r <= round_mode_t'(`RND_RST);
		end
		else if (init_op)
		begin
			mask_r <= `MASK_RST;
			rnd_r <= round_mode_t'(`RND_RST);
		end
		else if (w_ctrl)
		begin
			mask_r <= hwdata[`CTRL_MASK_LSB +: `NEXC];
			rnd_r <= round_mode_t'(hwdata[`CTRL_RND_LSB +: 2]);
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			native_r <= `NATIVE_RST;
		else if (w_mode)
			native_r <= hwdata[`MODE_NATIVE_BIT];
	end

	// =====================================================
	// exception resolution
	exc_vec_t fix_c;
	logic unm_c, zero_c, den_c, unm, legacy, ign;
	exc_resolve u_resolve
	(
		.raw_exc(op_exc),
		.mask(mask_r),
		.tiny_below_denorm(op_tiny_zero),
		.fixup(fix_c),
		.unmasked_any(unm_c),
		.store_zero(zero_c),
		.store_denorm(den_c)
	);
	assign unm = op_done & unm_c;
	assign legacy = !native_r;
	assign ign = legacy & !ign_s2_r;

	// =====================================================
	// sticky flags; a new event wins over a same-cycle clear
	exc_vec_t set_v;
	assign set_v = op_done ? op_exc : 6'h0;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			flags_r <= 6'h0;
			sf_r <= 1'h0;
		end
		else if (w_stat)
		begin
			flags_r <= hwdata[`NEXC-1:0] | set_v;
			sf_r <= hwdata[`STAT_SF_BIT] |
				(op_done & op_stack_fault & op_exc[`EXC_INV]);
		end
		else if (clr_op | init_op)
		begin
			flags_r <= set_v;
			sf_r <= op_done & op_stack_fault & op_exc[`EXC_INV];
		end
		else
		begin
			// no address or time of the event is stored
			flags_r <= flags_r | set_v;
			sf_r <= sf_r | (op_done & op_stack_fault & op_exc[`EXC_INV]);
		end
	end

	// =====================================================
	// pending fault and freeze sequencing
	always_comb
	begin
		st_nxt = st_r;
		unique case (st_r)
		st_idle:
			if (unm)
				st_nxt = st_pend;
		st_pend:
			if (clear_evt & !unm)
				st_nxt = st_idle;
			else if (op_sync & !op_nowait & legacy & !ign)
				st_nxt = st_frozen;
		st_frozen:
			if (clear_evt & !unm)
				st_nxt = st_idle;
			else if (irq_s2_r & irq_enable)
				st_nxt = st_pend;
		default: st_nxt = st_idle;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_r <= st_idle;
			freeze_out <= 1'h0;
		end
		else
		begin
			st_r <= st_nxt;
			freeze_out <= (st_nxt == st_frozen);
		end
	end

	// =====================================================
	// error pin: immediate or at next wait/numeric instruction
	logic err_set;
	assign err_set = legacy & ((unm & op_immediate) |
		((st_r != st_idle) & op_sync));
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			err_r <= 1'h0;
		else if (err_set)
			err_r <= 1'h1;
		else if (clear_evt | !legacy)
			err_r <= 1'h0;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			numeric_error_out <= 1'h0;
		else
			numeric_error_out <= err_set | (err_r & !clear_evt & legacy);
	end

	// =====================================================
	// per-instruction pulses and the round mode level to the datapath
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			abort_out <= 1'h0;
			native_trap_out <= 1'h0;
			fixup_out <= 6'h0;
			uf_zero_out <= 1'h0;
			uf_denorm_out <= 1'h0;
			round_mode_out <= round_mode_t'(`RND_RST);
		end
		else
		begin
			abort_out <= unm;
			native_trap_out <= native_r & (st_r != st_idle) & op_sync &
				!op_nowait;
			fixup_out <= op_done ? fix_c : 6'h0;
			uf_zero_out <= op_done & zero_c;
			uf_denorm_out <= op_done & den_c;
			round_mode_out <= rnd_r;
		end
	end

	// =====================================================
	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_abort_on_fault: assert property (unm |=> abort_out)
		else $error("unmasked fault did not abort");
	a_fixup_masked: assert property
		(op_done |=> fixup_out == ($past(op_exc) & $past(mask_r)))
		else $error("wrong fix-up set");
	a_flags_gather: assert property
		(op_done |=> (flags_r & $past(op_exc)) == $past(op_exc))
		else $error("detected exception not flagged");
	a_flags_sticky: assert property
		(!clear_evt |=> (flags_r & $past(flags_r)) == $past(flags_r))
		else $error("flag fell without clear");
	a_masked_quiet: assert property
		(st_r == st_idle && !err_r && !unm |=> !numeric_error_out)
		else $error("error pin without unmasked fault");
	a_err_immediate: assert property
		(unm && op_immediate && legacy |=> numeric_error_out)
		else $error("immediate error not reported");
	a_err_clear: assert property
		(clear_evt && !err_set |=> !numeric_error_out)
		else $error("error pin stayed after clear");
	a_freeze_enter: assert property
		(st_r == st_pend && op_sync && !op_nowait && legacy && !ign &&
		!clear_evt |=> freeze_out && st_r == st_frozen)
		else $error("no freeze on pending fault");
	a_ignore_run: assert property
		(st_r == st_pend && ign |=> !freeze_out)
		else $error("froze while ignoring errors");
	a_frozen_hold: assert property
		(st_r == st_frozen && !(irq_s2_r && irq_enable) && !clear_evt
		|=> freeze_out)
		else $error("left freeze without interrupt");

	c_masked_fixup: cover property (op_done && |fix_c && !unm_c);
	c_freeze_then_irq: cover property
		(freeze_out ##[1:50] !freeze_out && st_r == st_pend);
	c_ignored: cover property (st_r == st_pend && ign && op_sync);
	c_cleared: cover property (numeric_error_out ##[1:50] !numeric_error_out);
endmodule

// [dv/irq_glue_model.sv]
// interrupt glue model between the error pin and the core interrupt pin
`timescale 1ns/1ps
module irq_glue_model
(
	input wire clk,
	input wire rst_n,
	input wire err_pin,
	input wire latch_clr,
	input wire line_en,
	input wire slow,
	output logic core_irq
);
	logic req_r;
	logic err_d_r;
	logic [2:0] dly_r;
	// =======================================
	// request latch, set on the rising pin
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			req_r <= 1'b0;
			err_d_r <= 1'b0;
		end
		else
		begin
			err_d_r <= err_pin;
			if (latch_clr)
				req_r <= 1'b0;
			else if (err_pin && !err_d_r)
				req_r <= 1'b1;
		end
	end
	// =======================================
	// request to core, optionally late
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dly_r <= 3'h0;
			core_irq <= 1'b0;
		end
		else
		begin
			dly_r <= req_r ? dly_r + 3'(dly_r != 3'h7) : 3'h0;
			core_irq <= req_r && line_en &&
				(!slow || dly_r == 3'h7);
		end
	end
endmodule

// [dv/fpu_exception_signalling_tb.sv]
// self-checking bench for the numeric exception unit
`timescale 1ns/1ps
`include "fpu_exc_params.svh"
module fpu_exception_signalling_tb;
	import fpu_exc_pkg::*;
	logic hclk = 1'b0;
	logic hresetn, hsel, hwrite, hrdy, hresp, op_done, op_sf, op_tz, op_imm;
	logic op_sync, op_nw, irq_en, ign_n, core_irq, err, frz, abrt, ntrap;
	logic uz, ud, clr, line_en, slow;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [5:0] op_exc, fix;
	round_mode_t rnd;
	int fail_count = 0;
	int checks_done = 0;
	int cyc = 0;
	always #50 hclk = ~hclk;
	fpu_exc_unit uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy),
		.hresp(hresp), .op_done(op_done), .op_exc(op_exc),
		.op_stack_fault(op_sf), .op_tiny_zero(op_tz), .op_immediate(op_imm),
		.op_sync(op_sync), .op_nowait(op_nw), .irq_enable(irq_en),
		.ignore_numeric_error_in_n(ign_n), .maskable_interrupt_in(core_irq),
		.numeric_error_out(err), .freeze_out(frz), .abort_out(abrt),
		.native_trap_out(ntrap), .fixup_out(fix), .uf_zero_out(uz),
		.uf_denorm_out(ud), .round_mode_out(rnd));
	irq_glue_model glue (.clk(hclk), .rst_n(hresetn), .err_pin(err),
		.latch_clr(clr), .line_en(line_en), .slow(slow),
		.core_irq(core_irq));
	// =======================================
	// shared tasks
	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= 32'(a);
		hwrite <= w;
		@(posedge hclk);
		while (!hrdy) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (!hrdy) @(posedge hclk);
		rd = hrdata;
		#1;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk("reg", rd, e);
		chk("resp", 32'(hresp), 32'h0);
	endtask
	task automatic op(input logic [5:0] x, input logic imm, input logic tz,
		input logic sf);
		@(posedge hclk);
		op_done <= 1'b1;
		op_exc <= x;
		op_imm <= imm;
		op_tz <= tz;
		op_sf <= sf;
		@(posedge hclk);
		op_done <= 1'b0;
		#1;
	endtask
	task automatic sync(input logic nw);
		@(posedge hclk);
		op_sync <= 1'b1;
		op_nw <= nw;
		@(posedge hclk);
		op_sync <= 1'b0;
		#1;
	endtask
	// handler: drop the glue latch first, then clear the unit
	task automatic handler;
		@(posedge hclk);
		clr <= 1'b1;
		@(posedge hclk);
		clr <= 1'b0;
		bus(1'b1, `OFS_CMD, 32'h1);
		repeat (2) @(posedge hclk);
		#1;
		chk("err", err, 1'b0);
	endtask
	// =======================================
	// scenarios
	task automatic t_regs;
		rchk(`OFS_CTRL, 32'h3f);
		rchk(`OFS_MODE, 32'h0);
		rchk(8'h10, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b1, `OFS_CTRL, {20'h0, 2'(i), 10'h3f});
			// round output is registered one edge after the write lands
			@(posedge hclk);
			#1;
			chk("rnd", 32'(rnd), i);
		end
		bus(1'b1, `OFS_STAT, 32'h5);
		rchk(`OFS_STAT, 32'h5);
		$display("done t_regs");
	endtask
	task automatic t_masked;
		bus(1'b1, `OFS_CMD, 32'h1);
		for (int i = 0; i < 6; i++)
		begin
			op(6'h1 << i, 1'b0, 1'b0, 1'b0);
			chk("fix", fix, 6'h1 << i);
			chk("abort", abrt, 1'b0);
		end
		op(6'h12, 1'b0, 1'b1, 1'b0);
		chk("fix2", fix, 6'h12);
		chk("uz", uz, 1'b1);
		op(6'h10, 1'b0, 1'b0, 1'b0);
		chk("ud", ud, 1'b1);
		chk("err", err, 1'b0);
		rchk(`OFS_STAT, 32'h3f);
		bus(1'b1, `OFS_CMD, 32'h4);
		rchk(`OFS_STAT, 32'h0);
		$display("done t_masked");
	endtask
	task automatic t_fault(input logic s);
		@(posedge hclk);
		slow <= s;
		irq_en <= 1'b0;
		bus(1'b1, `OFS_CTRL, 32'h3e);
		op(6'h01, 1'b0, 1'b0, 1'b1);
		chk("abort", abrt, 1'b1);
		chk("err", err, 1'b0);
		sync(1'b1);
		chk("frz", frz, 1'b0);
		chk("err", err, 1'b1);
		sync(1'b0);
		chk("frz", frz, 1'b1);
		repeat (20) @(posedge hclk);
		rchk(`OFS_STAT, 32'h3c1);
		@(posedge hclk);
		irq_en <= 1'b1;
		for (int n = 0; n < 40 && frz; n++) @(posedge hclk);
		#1;
		chk("frz", frz, 1'b0);
		handler();
		$display("done t_fault");
	endtask
	task automatic t_ignore;
		@(posedge hclk);
		ign_n <= 1'b0;
		op(6'h01, 1'b1, 1'b0, 1'b0);
		chk("err", err, 1'b1);
		sync(1'b0);
		chk("frz", frz, 1'b0);
		handler();
		@(posedge hclk);
		ign_n <= 1'b1;
		bus(1'b1, `OFS_MODE, 32'h1);
		op(6'h01, 1'b1, 1'b0, 1'b0);
		sync(1'b0);
		chk("trap", ntrap, 1'b1);
		chk("err", err, 1'b0);
		chk("frz", frz, 1'b0);
		bus(1'b1, `OFS_CMD, 32'h1);
		$display("done t_ignore");
	endtask
	// =======================================
	// verdict and run
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// cut a hang short; the whole run needs well under this
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fail_count++;
			give_verdict();
		end
	end
	initial
	begin
		{hresetn, hsel, hwrite, op_done, op_sf, op_tz, op_imm} = '0;
		{op_sync, op_nw, irq_en, clr, slow} = '0;
		{ign_n, line_en} = 2'h3;
		{htrans, haddr, hwdata, op_exc} = '0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_masked();
		t_fault(1'b0);
		t_fault(1'b1);
		t_ignore();
		give_verdict();
	end
endmodule
